// >>> verilog/dual_six_bit_pwm_trim_dac.sv
// Purpose: two six-bit duty-cycle trim channels with pulse and pushbutton control
// Assumes: pad logic reports level and whether a step pin is driven
//          mode is fixed from the first clock after reset
// Notes: sleep tristates outputs; counts are parameters so they can be shortened
//        codes stay readable on ports for trim read-back
`include "pwm_trim_cfg.svh"
`default_nettype none
module dual_six_bit_pwm_trim_dac #(
	parameter int TICK_CYC       = `TICK_CYC,
	parameter int DEBOUNCE_CYC   = `DEBOUNCE_CYC,
	parameter int REPEAT_DLY_CYC = `REPEAT_DLY_CYC,
	parameter int REPEAT_CYC     = `REPEAT_CYC
) (
	input  wire logic                     mclk,              // 20 MHz clock
	input  wire logic                     reset_n,           // Sync reset, power-up
	input  wire pwm_trim_pkg::step_pin_s  chan1_step_input,  // Channel 1 step pin
	input  wire pwm_trim_pkg::step_pin_s  chan2_step_input,  // Channel 2 step pin
	input  wire logic                     sleep_n,           // Low puts outputs in hi-z
	output logic                          chan1_duty_output, // Channel 1 PWM level
	output logic                          chan1_duty_oe_n,   // Low while driving
	output logic                          chan2_duty_output, // Channel 2 PWM level
	output logic                          chan2_duty_oe_n,   // Low while driving
	output logic                          button_mode,       // Latched interface mode
	output logic [5:0]                    chan1_code,        // Channel 1 code
	output logic [5:0]                    chan2_code         // Channel 2 code
);
	// Counter widths sized from the counts they must reach
	localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
	localparam int RW  = $clog2(REPEAT_DLY_CYC + REPEAT_CYC + 1);
	localparam int TW  = $clog2(TICK_CYC + 1);

	// Refuse counts the logic cannot serve; each needs at least one cycle
	// Wide counts only cost flops; too small ones break the timing
	if (TICK_CYC < 1) begin : g_bad_tick
		$error("dual_six_bit_pwm_trim_dac: TICK_CYC must be at least one");
	end
	if (DEBOUNCE_CYC < 1) begin : g_bad_debounce
		$error("dual_six_bit_pwm_trim_dac: DEBOUNCE_CYC must be at least one");
	end
	if (REPEAT_DLY_CYC < 1) begin : g_bad_delay
		$error("dual_six_bit_pwm_trim_dac: REPEAT_DLY_CYC must be at least one");
	end
	if (REPEAT_CYC < 1) begin : g_bad_repeat
		$error("dual_six_bit_pwm_trim_dac: REPEAT_CYC must be at least one");
	end

	// Interface mode, latched once after reset
	logic        mode_q;
	logic        sensed_q;
	logic        steps_on;

	// Shared timebase: tick divider and 64-step phase
	logic [TW-1:0] tick_div_q;
	logic [5:0]  phase_q;
	logic        tick_end;

	// Pad views, one bit per channel for the generate loop
	logic [1:0]  lvl;
	logic [1:0]  drv;

	// Pad fields gathered per channel
	assign lvl = {chan2_step_input.level, chan1_step_input.level};
	assign drv = {chan2_step_input.driven, chan1_step_input.driven};
	// Mode shown on a port for status
	assign button_mode = mode_q;

	// No step before the mode is known; also masks a false edge after reset
	assign steps_on = sensed_q;

	// Mode sensed once, on the first edge after reset release
	// Step pins must be steady across that edge; later changes are ignored
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sensed_q <= 1'b0;
			mode_q   <= pwm_trim_pkg::MODE_PULSE;
		end else if (!sensed_q) begin
			sensed_q <= 1'b1;
			mode_q   <= (drv == 2'b00) ? pwm_trim_pkg::MODE_BUTTON
			                           : pwm_trim_pkg::MODE_PULSE;
		end
	end

	// Free-running timebase; 64 ticks form one period near 5 kHz
	// Sleep leaves it running, so waveforms resume in phase
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tick_div_q <= '0;
			phase_q    <= 6'h00;
		end else if (tick_end) begin
			tick_div_q <= '0;
			phase_q    <= phase_q + 6'h01;
		end else begin
			tick_div_q <= tick_div_q + TW'(1);
		end
	end
	// Last cycle of one tick; phase wraps 63 to 0 by overflow
	assign tick_end = (tick_div_q == TW'(TICK_CYC - 1));

	// Per-channel output and code state
	logic [1:0] duty_q;
	logic [5:0] code_q [2];

	// One generate loop: each step input steers only its own channel
	for (genvar c = 0; c < 2; c++) begin : g_chan
		// Debounce state
		logic          prev_q;
		logic          stable_q;
		logic [DBW-1:0] db_q;

		// Press and auto-repeat state
		logic          pressed_q;
		logic          up_q;
		logic [RW-1:0] rep_q;
		logic          rep_hit;

		// Step strobes into the code counter
		logic          rise;
		logic          step_up;
		logic          step_dn;

		// Pulse edge: level high now, low one sample earlier
		assign rise = lvl[c] && !prev_q;

		// Repeat point: hold delay plus one repeat period passed, then every repeat period
		assign rep_hit = pressed_q && rep_q == RW'(REPEAT_DLY_CYC + REPEAT_CYC - 1);

		// Debounce: a new level must hold for the full debounce time
		// A floating pin keeps the counter cleared, so release never steps
		always_ff @(posedge mclk) begin
			if (!reset_n) begin
				prev_q   <= 1'b0;
				stable_q <= 1'b0;
				db_q     <= '0;
			end else begin
				prev_q <= lvl[c];
				if (lvl[c] != prev_q || !drv[c]) begin
					db_q <= '0;
				end else if (db_q != DBW'(DEBOUNCE_CYC)) begin
					db_q <= db_q + DBW'(1);
				end
				stable_q <= (db_q == DBW'(DEBOUNCE_CYC - 1)) && drv[c] && lvl[c] == prev_q;
			end
		end

		// Press tracking with auto-repeat after the hold delay
		// Release clears the hold, so each press starts its own delay
		always_ff @(posedge mclk) begin
			if (!reset_n) begin
				pressed_q <= 1'b0;
				up_q      <= 1'b0;
				rep_q     <= '0;
			end else if (!drv[c]) begin
				pressed_q <= 1'b0; // Released: pin floats again
				rep_q     <= '0;
			end else if (stable_q) begin
				pressed_q <= 1'b1;
				up_q      <= prev_q;
				rep_q     <= '0;
			end else if (pressed_q) begin
				if (rep_q == RW'(REPEAT_DLY_CYC + REPEAT_CYC - 1))
					rep_q <= RW'(REPEAT_DLY_CYC);
				else
					rep_q <= rep_q + RW'(1);
			end
		end

		// Step strobes for each mode; silent until the mode is latched
		always_comb begin
			step_up = 1'b0;
			step_dn = 1'b0;
			if (!steps_on) begin
				step_up = 1'b0;
			end else if (mode_q == pwm_trim_pkg::MODE_PULSE) begin
				step_up = rise;
			end else if (stable_q) begin
				// First step once the press has settled
				step_up = prev_q;
				step_dn = !prev_q;
			end else if (rep_hit) begin
				// Held press repeats in the direction of the last settled level
				step_up = up_q;
				step_dn = !up_q;
			end
		end

		// Code counter; kept through sleep, preset only by reset
		// Pulse mode wraps 63 to 0 by plain overflow; buttons saturate
		// Steps only ever come from the strobes above
		always_ff @(posedge mclk) begin
			if (!reset_n) begin
				code_q[c] <= `CODE_MID;
			end else if (mode_q == pwm_trim_pkg::MODE_PULSE && step_up) begin
				code_q[c] <= code_q[c] + 6'h01;
			end else if (step_up && code_q[c] != `CODE_MAX) begin
				code_q[c] <= code_q[c] + 6'h01;
			end else if (step_dn && code_q[c] != `CODE_MIN) begin
				code_q[c] <= code_q[c] - 6'h01;
			end
		end

		// Output high while phase below code; 63 gives 63/64 duty
		// Registered so the pad sees no compare glitches
		always_ff @(posedge mclk) begin
			if (!reset_n)
				duty_q[c] <= 1'b0;
			else
				duty_q[c] <= (phase_q < code_q[c]);
		end
	end

	// Codes and duty levels leave through plain wires
	assign chan1_code        = code_q[0];
	assign chan2_code        = code_q[1];
	assign chan1_duty_output = duty_q[0];
	assign chan2_duty_output = duty_q[1];
	// Sleep only releases the pads; codes and timebase run on
	assign chan1_duty_oe_n   = !sleep_n;
	assign chan2_duty_oe_n   = !sleep_n;

	// Limitation: swapping press direction mid-hold repeats the old way until the new level settles
endmodule : dual_six_bit_pwm_trim_dac
`default_nettype wire

// >>> verilog/pwm_trim_cfg.svh
// Purpose: constants for the dual six-bit duty-cycle trim block
// Assumes: mclk at 20 MHz, synchronous active-low reset
// Notes: times are given in their own unit, cycle counts derived here
`ifndef PWM_TRIM_CFG_SVH
`define PWM_TRIM_CFG_SVH

`define CLK_HZ          20000000
`define CODE_W          6
`define CODE_MID        6'h20
`define CODE_MAX        6'h3f
`define CODE_MIN        6'h00
`define PWM_HZ          5000
`define TICK_CYC        (`CLK_HZ / (`PWM_HZ * 64))
`define DEBOUNCE_US     12800
`define DEBOUNCE_CYC    ((`CLK_HZ / 1000000) * `DEBOUNCE_US)
`define REPEAT_DLY_US   410000
`define REPEAT_DLY_CYC  ((`CLK_HZ / 1000000) * `REPEAT_DLY_US)
`define REPEAT_MHZ      19500
`define REPEAT_CYC      ((`CLK_HZ / `REPEAT_MHZ) * 1000)

`endif

// >>> verilog/pwm_trim_pkg.sv
// Purpose: types for the dual six-bit duty-cycle trim block
// Assumes: constants live in pwm_trim_cfg.svh
// Notes: none
`default_nettype none
package pwm_trim_pkg;
	typedef enum logic [0:0] {
		MODE_PULSE  = 1'b0,
		MODE_BUTTON = 1'b1
	} mode_e;

	// Per-channel step input seen as two signals
	typedef struct packed {
		logic level;  // Sampled logic level
		logic driven; // Low when pin floats
	} step_pin_s;
endpackage : pwm_trim_pkg
`default_nettype wire

// >>> bench/pwm_trim_assertions.sv
// Purpose: port checks for the trim block
// Assumes: one pulse step lands one edge after it is seen
// Notes: bound from the bench top
`default_nettype none
module pwm_trim_assertions (
	input wire logic                    mclk,             // Clock
	input wire logic                    reset_n,          // Reset
	input wire pwm_trim_pkg::step_pin_s chan1_step_input, // Pin 1
	input wire logic                    sleep_n,          // Sleep
	input wire logic                    chan1_duty_output,// PWM 1
	input wire logic                    chan1_duty_oe_n,  // Enable 1
	input wire logic                    chan2_duty_oe_n,  // Enable 2
	input wire logic                    button_mode,      // Mode
	input wire logic [5:0]              chan1_code,       // Code 1
	input wire logic [5:0]              chan2_code        // Code 2
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Press start, then a quiet code while debounce runs
	sequence s_press; button_mode && $rose(chan1_step_input.driven); endsequence
	sequence s_quiet; $stable(chan1_code) [*6]; endsequence
	AST_OE: assert property (chan1_duty_oe_n == !sleep_n && chan2_duty_oe_n == !sleep_n)
		else $error("enable not following sleep");
	AST_MID: assert property ($rose(reset_n) |-> chan1_code == 6'h20 && chan2_code == 6'h20)
		else $error("codes not midscale");
	AST_MODE: assert property (reset_n && $past(reset_n) |=> $stable(button_mode))
		else $error("mode changed");
	AST_ZERO: assert property ($past(chan1_code) == 6'h00 |-> !chan1_duty_output)
		else $error("duty high at code zero");
	AST_INC: assert property ($past(reset_n) && !button_mode
		&& $rose(chan1_step_input.level) |=> chan1_code == $past(chan1_code) + 6'h01)
		else $error("pulse step wrong");
	AST_ISO: assert property (!button_mode && !$rose(chan1_step_input.level)
		|=> $stable(chan1_code))
		else $error("code moved without pulse");
	AST_SAT: assert property (button_mode && chan1_code == 6'h3f |=> chan1_code != 6'h00)
		else $error("button wrapped");
	AST_DEB: assert property (s_press |=> s_quiet)
		else $error("step before debounce");
endmodule : pwm_trim_assertions
`default_nettype wire

// >>> bench/step_source.sv
// Purpose: step pin model, controller port or pushbutton
// Assumes: pad reports whether the pin is driven
// Notes: floating level toggles so no stale value passes
`default_nettype none
module step_source (
	input  wire logic                   mclk,    // Clock
	input  wire logic                   float_i, // Pin released
	input  wire logic                   level_i, // Driven level
	output var pwm_trim_pkg::step_pin_s pin      // To block
);
	initial pin = 2'b00;
	// Holds are set by the caller, long enough to pass debounce
	always @(posedge mclk) begin
		pin.driven <= !float_i;
		pin.level <= float_i ? !pin.level : level_i;
	end
endmodule : step_source
`default_nettype wire

// >>> bench/dual_six_bit_pwm_trim_dac_bench.sv
// Purpose: self-checking bench for the trim block
// Assumes: short counts, tick of two cycles
// Notes: pins come from step_source models
`default_nettype none
module dual_six_bit_pwm_trim_dac_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, reset_n = 1'b0, sleep_n = 1'b1, b1, b2, m;
	logic [1:0] fl = 2'b00, lv = 2'b00, oe;
	logic [5:0] c1, c2;
	pwm_trim_pkg::step_pin_s p1, p2;
	int fail_count = 0, tests_run = 0, cyc = 0;
	always #25 mclk = ~mclk;
	step_source s1 (.mclk(mclk), .float_i(fl[0]), .level_i(lv[0]), .pin(p1));
	step_source s2 (.mclk(mclk), .float_i(fl[1]), .level_i(lv[1]), .pin(p2));
	dual_six_bit_pwm_trim_dac #(.TICK_CYC(2), .DEBOUNCE_CYC(8), .REPEAT_DLY_CYC(40),
		.REPEAT_CYC(10)) dut (.mclk(mclk), .reset_n(reset_n), .chan1_step_input(p1),
		.chan2_step_input(p2), .sleep_n(sleep_n), .chan1_duty_output(b1),
		.chan1_duty_oe_n(oe[0]), .chan2_duty_output(b2), .chan2_duty_oe_n(oe[1]),
		.button_mode(m), .chan1_code(c1), .chan2_code(c2));
	task automatic check(input string n, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	// Hang guard, well above the whole run
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	task automatic do_reset(input logic [1:0] f);
		@(posedge mclk);
		reset_n <= 1'b0;
		fl <= f;
		lv <= 2'b00;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : do_reset
	task automatic pulse(input int ch, n);
		@(posedge mclk);
		repeat (n) begin
			lv[ch] <= 1'b1;
			repeat (2) @(posedge mclk);
			lv[ch] <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask : pulse
	task automatic press(input int ch, input logic v, input int n);
		@(posedge mclk);
		fl[ch] <= 1'b0;
		lv[ch] <= v;
		repeat (n) @(posedge mclk);
		fl[ch] <= 1'b1;
		repeat (20) @(posedge mclk);
	endtask : press
	// High samples over one 128-cycle period
	task automatic duty(input int ch, input logic [7:0] exp);
		logic [7:0] h;
		h = 8'h00;
		repeat (128) begin
			@(negedge mclk);
			h += ch ? b2 : b1;
		end
		check("duty", h, exp);
	endtask : duty
	// Outputs are read at the falling edge, away from the launching edge
	task automatic t_pulse;
		do_reset(2'b00);
		@(negedge mclk);
		check("mode", m, 8'h00);
		check("code1", c1, 8'h20);
		pulse(0, 31);
		@(negedge mclk);
		check("code1", c1, 8'h3f);
		duty(0, 8'h7e);
		duty(1, 8'h40);
		pulse(0, 1);
		@(negedge mclk);
		check("code1", c1, 8'h00);
		duty(0, 8'h00);
		check("code2", c2, 8'h20);
	endtask : t_pulse
	task automatic t_sleep;
		@(posedge mclk);
		sleep_n <= 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		check("oe", oe, 8'h03);
		@(posedge mclk);
		sleep_n <= 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		check("oe", oe, 8'h00);
		check("code1", c1, 8'h00);
		check("code2", c2, 8'h20);
		pulse(1, 1);
		@(negedge mclk);
		check("code2", c2, 8'h21);
		check("code1", c1, 8'h00);
	endtask : t_sleep
	task automatic t_button;
		do_reset(2'b11);
		@(negedge mclk);
		check("mode", m, 8'h01);
		check("code1", c1, 8'h20);
		press(0, 1'b1, 20);
		@(negedge mclk);
		check("code1", c1, 8'h21);
		press(0, 1'b0, 20);
		@(negedge mclk);
		check("code1", c1, 8'h20);
		press(0, 1'b1, 800);
		@(negedge mclk);
		check("code1", c1, 8'h3f);
		press(0, 1'b0, 800);
		@(negedge mclk);
		check("code1", c1, 8'h00);
		check("code2", c2, 8'h20);
		do_reset(2'b01);
		@(negedge mclk);
		check("mode", m, 8'h00);
	endtask : t_button
	initial begin
		t_pulse;
		t_sleep;
		t_button;
		tally_and_finish;
	end
endmodule : dual_six_bit_pwm_trim_dac_bench
bind dual_six_bit_pwm_trim_dac pwm_trim_assertions chk (.*);
`default_nettype wire
